// ---- sim_pkg.sv ----
// Purpose : shared constants of the safety interlock monitor
// Assumes : clk_sys at 250 MHz
// Notes   : times in their own unit, cycle counts derived from them
package sim_pkg;

  // =====================================================================
  // timing
  localparam longint unsigned CLK_HZ           = 64'd250_000_000;
  localparam longint unsigned DISAGREE_TIME_MS = 64'd2000;
  localparam longint unsigned DISAGREE_CYC_L   = (CLK_HZ * DISAGREE_TIME_MS + 64'd999) / 64'd1000;
  localparam int unsigned     DISAGREE_CYC     = 32'(DISAGREE_CYC_L);
  localparam int              TMR_W            = 32;

  // =====================================================================
  // synchroniser layout
  localparam int SYNC_STAGES = 3;
  localparam int NUM_IN      = 6;
  localparam int IN_DOOR1    = 0;
  localparam int IN_DOOR2    = 1;
  localparam int IN_STOP1    = 2;
  localparam int IN_STOP2    = 3;
  localparam int IN_RELEASE  = 4;
  localparam int IN_TEACH    = 5;

  // =====================================================================
  // reset values
  localparam logic [NUM_IN-1:0] SYNC_RST = 6'h00;
  localparam logic              FLAG_RST = 1'h0;

endpackage : sim_pkg

// ---- sim_pair_timer.sv ----
// Purpose : times disagreement of one redundant input pair
// Assumes : both inputs already synchronised to clk_sys
// Notes   : expired stays high while the disagreement lasts past the limit
`timescale 1ns/1ps
module sim_pair_timer
  import sim_pkg::*;
#(
  parameter int unsigned LIMIT = DISAGREE_CYC
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic chan_a,
  input  wire logic chan_b,
  output logic      expired
);

  logic [TMR_W-1:0] cnt_ff;
  logic [TMR_W-1:0] nxt_cnt;
  logic             exp_ff;
  logic             nxt_exp;

  // =====================================================================
  // next state
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_exp = 1'b0;
    if (chan_a == chan_b) begin
      nxt_cnt = '0;                                    // see RULE15
    end else if (cnt_ff >= TMR_W'(LIMIT - 1)) begin
      nxt_cnt = cnt_ff;
      nxt_exp = 1'b1;
    end else begin
      nxt_cnt = cnt_ff + TMR_W'(1);
    end
  end

  // =====================================================================
  // registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      exp_ff <= FLAG_RST;
    end else begin
      cnt_ff <= nxt_cnt;
      exp_ff <= nxt_exp;
    end
  end

  assign expired = exp_ff;

endmodule : sim_pair_timer

// ---- sim_safety_monitor.sv ----
// Purpose : safety door, teach mode and emergency stop monitor
// Assumes : contacts are high when closed; reset_cmd is a clk_sys pulse
// Notes   : pins pass three flops; a change counts when stages two and three agree
//
// Function
// RULE1 - latch door-open record while latch release is open, even after closing
// RULE2 - with latch release closed, do not latch; safety follows the door
// RULE3 - door latch clears only when door closed first, then release closed
// RULE4 - latch change into teach mode; release closure acknowledges it
// RULE5 - teach latch clears when selector is automatic, then release closed
// RULE6 - door channels disagreeing two seconds or more raise critical error
// RULE7 - stop channels disagreeing two seconds or more raise critical error
// RULE8 - safety indication active from open-door start until close then release
// RULE9 - stop pressed at start lights stop indicator and status
// RULE10 - stop state holds after button release until a reset command
// RULE11 - outside party delays door input until initialisation is over
// RULE12 - stop button is normally closed, latching, with double contacts
// RULE13 - clearing teach latch with door open keeps operation prohibited
// RULE14 - door opening pauses program or prohibits operation
// RULE15 - disagreement timer restarts when the pair agrees again
`timescale 1ns/1ps
module sim_safety_monitor
  import sim_pkg::*;
#(
  parameter int unsigned DISAGREE_LIMIT = DISAGREE_CYC
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic door_channel_one_a,
  input  wire logic door_channel_two_a,
  input  wire logic stop_contact_one_a,
  input  wire logic stop_contact_two_a,
  input  wire logic door_latch_release_a,
  input  wire logic teach_mode_sel,
  input  wire logic reset_cmd,
  output logic      safety_active_ff,
  output logic      door_latched_ff,
  output logic      teach_latched_ff,
  output logic      estop_active_ff,
  output logic      critical_error_ff,
  output logic      program_pause_ff,
  output logic      motion_prohibit_ff
);

  // =====================================================================
  // input synchronisers
  logic [NUM_IN-1:0] pin_in;
  logic [NUM_IN-1:0] s1_ff;
  logic [NUM_IN-1:0] s2_ff;
  logic [NUM_IN-1:0] s3_ff;
  logic [NUM_IN-1:0] filt_ff;
  logic [NUM_IN-1:0] nxt_filt;

  assign pin_in[IN_DOOR1]   = door_channel_one_a;
  assign pin_in[IN_DOOR2]   = door_channel_two_a;
  assign pin_in[IN_STOP1]   = stop_contact_one_a;
  assign pin_in[IN_STOP2]   = stop_contact_two_a;
  assign pin_in[IN_RELEASE] = door_latch_release_a;
  assign pin_in[IN_TEACH]   = teach_mode_sel;

  always_comb begin
    nxt_filt = filt_ff;
    for (int i = 0; i < NUM_IN; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_filt[i] = s3_ff[i];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s1_ff   <= SYNC_RST;
      s2_ff   <= SYNC_RST;
      s3_ff   <= SYNC_RST;
      filt_ff <= SYNC_RST;
    end else begin
      s1_ff   <= pin_in;
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      filt_ff <= nxt_filt;
    end
  end

  // =====================================================================
  // decoded conditions
  logic door_open;
  logic stop_pressed;
  logic release_closed;
  logic teach_now;
  logic door_err;
  logic stop_err;

  assign door_open      = !(filt_ff[IN_DOOR1] && filt_ff[IN_DOOR2]);
  assign stop_pressed   = !(filt_ff[IN_STOP1] && filt_ff[IN_STOP2]); // see RULE12
  assign release_closed = filt_ff[IN_RELEASE];
  assign teach_now      = filt_ff[IN_TEACH];

  // =====================================================================
  // disagreement timers
  sim_pair_timer #(
    .LIMIT   (DISAGREE_LIMIT)
  ) u_door_tmr (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .chan_a  (filt_ff[IN_DOOR1]),
    .chan_b  (filt_ff[IN_DOOR2]),
    .expired (door_err)                                // see RULE6
  );

  sim_pair_timer #(
    .LIMIT   (DISAGREE_LIMIT)
  ) u_stop_tmr (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .chan_a  (filt_ff[IN_STOP1]),
    .chan_b  (filt_ff[IN_STOP2]),
    .expired (stop_err)                                // see RULE7
  );

  // =====================================================================
  // release and selector edge history
  logic rel_prev_ff;
  logic teach_prev_ff;
  logic nxt_rel_prev;
  logic nxt_teach_prev;
  logic release_rise;
  logic teach_rise;

  assign release_rise = release_closed && !rel_prev_ff;
  assign teach_rise   = teach_now && !teach_prev_ff;

  always_comb begin
    nxt_rel_prev   = release_closed;
    nxt_teach_prev = teach_now;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rel_prev_ff   <= FLAG_RST;
      teach_prev_ff <= FLAG_RST;
    end else begin
      rel_prev_ff   <= nxt_rel_prev;
      teach_prev_ff <= nxt_teach_prev;
    end
  end

  // =====================================================================
  // door latch
  logic nxt_door_latched;

  always_comb begin
    nxt_door_latched = door_latched_ff;
    if (door_open && !release_closed) begin
      nxt_door_latched = 1'h1;                         // see RULE1 RULE2
    end else if (release_rise && !door_open) begin
      nxt_door_latched = 1'h0;                         // see RULE3
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      door_latched_ff <= FLAG_RST;
    end else begin
      door_latched_ff <= nxt_door_latched;
    end
  end

  // =====================================================================
  // teach latch
  logic nxt_teach_latched;

  always_comb begin
    nxt_teach_latched = teach_latched_ff;
    if (teach_rise) begin
      nxt_teach_latched = 1'h1;                        // see RULE4
    end else if (release_rise && !teach_now) begin
      nxt_teach_latched = 1'h0;                        // see RULE4 RULE5
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      teach_latched_ff <= FLAG_RST;
    end else begin
      teach_latched_ff <= nxt_teach_latched;
    end
  end

  // =====================================================================
  // emergency stop and critical error
  logic nxt_estop;
  logic nxt_crit;

  always_comb begin
    nxt_estop = estop_active_ff;
    if (stop_pressed) begin
      nxt_estop = 1'h1;                                // see RULE9
    end else if (reset_cmd) begin
      nxt_estop = 1'h0;                                // see RULE10
    end

    nxt_crit = critical_error_ff;
    if (door_err || stop_err) begin
      nxt_crit = 1'h1;                                 // see RULE6 RULE7
    end else if (reset_cmd) begin
      nxt_crit = 1'h0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      estop_active_ff   <= FLAG_RST;
      critical_error_ff <= FLAG_RST;
    end else begin
      estop_active_ff   <= nxt_estop;
      critical_error_ff <= nxt_crit;
    end
  end

  // =====================================================================
  // indications
  logic nxt_safety;
  logic nxt_pause;
  logic nxt_prohibit;

  always_comb begin
    nxt_safety   = door_open || nxt_door_latched;      // see RULE2 RULE8
    nxt_pause    = door_open;                          // see RULE14
    nxt_prohibit = nxt_safety || nxt_teach_latched
                   || nxt_estop || nxt_crit;           // see RULE13 RULE14
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      safety_active_ff   <= FLAG_RST;
      program_pause_ff   <= FLAG_RST;
      motion_prohibit_ff <= FLAG_RST;
    end else begin
      safety_active_ff   <= nxt_safety;
      program_pause_ff   <= nxt_pause;
      motion_prohibit_ff <= nxt_prohibit;
    end
  end

endmodule : sim_safety_monitor

// ---- sim_safety_monitor_properties.sv ----
// Purpose: checker of the safety interlock monitor
// Assumes: pins stay steady for several cycles
// Notes: bound into sim_safety_monitor
`timescale 1ns/1ps
module sim_safety_monitor_properties #(parameter int unsigned DISAGREE_LIMIT = 20) (
  input wire logic clk_sys, rst_n, door_channel_one_a, door_channel_two_a, stop_contact_one_a,
  input wire logic stop_contact_two_a, door_latch_release_a, teach_mode_sel, reset_cmd,
  input wire logic safety_active_ff, door_latched_ff, teach_latched_ff, estop_active_ff,
  input wire logic critical_error_ff
);
  // ==========
  // pin disagreement counter
  logic [31:0] cnt_ff, nxt_cnt;
  always_comb begin
    nxt_cnt = 32'h0;
    if ((door_channel_one_a != door_channel_two_a) || (stop_contact_one_a != stop_contact_two_a)) nxt_cnt = cnt_ff + 32'h1;
  end
  always_ff @(posedge clk_sys) cnt_ff <= rst_n ? nxt_cnt : 32'h0;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_latch_safe; door_latched_ff |-> safety_active_ff; endproperty
  a_latch_safe: assert property (p_latch_safe) else $error("door latch without safety");
  property p_no_latch; $rose(door_latched_ff) |-> !($past(door_latch_release_a, 4) && $past(door_latch_release_a, 5));
  endproperty
  a_no_latch: assert property (p_no_latch) else $error("door latched with release closed");
  property p_door_clr; $fell(door_latched_ff) |-> $past(door_channel_one_a, 3) && $past(door_channel_two_a, 3)
    && $past(door_latch_release_a, 3); endproperty
  a_door_clr: assert property (p_door_clr) else $error("door latch cleared early");
  property p_teach_set; $rose(teach_mode_sel) && !door_latch_release_a |-> ##[3:7] teach_latched_ff; endproperty
  a_teach_set: assert property (p_teach_set) else $error("teach change not latched");
  property p_teach_clr; $fell(teach_latched_ff) |-> !$past(teach_mode_sel, 3) && $past(door_latch_release_a, 3);
  endproperty
  a_teach_clr: assert property (p_teach_clr) else $error("teach latch cleared early");
  property p_stop_set; !(stop_contact_one_a && stop_contact_two_a) |-> ##[0:6] estop_active_ff; endproperty
  a_stop_set: assert property (p_stop_set) else $error("stop not indicated");
  property p_stop_hold; estop_active_ff && !reset_cmd |=> estop_active_ff; endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop cleared without reset");
  property p_crit_set; cnt_ff == DISAGREE_LIMIT + 8 |-> ##[0:2] critical_error_ff; endproperty
  a_crit_set: assert property (p_crit_set) else $error("no critical error");
endmodule : sim_safety_monitor_properties
bind sim_safety_monitor sim_safety_monitor_properties #(.DISAGREE_LIMIT(DISAGREE_LIMIT)) u_props (
  .clk_sys(clk_sys), .rst_n(rst_n), .door_channel_one_a(door_channel_one_a), .door_channel_two_a(door_channel_two_a),
  .stop_contact_one_a(stop_contact_one_a), .stop_contact_two_a(stop_contact_two_a), .reset_cmd(reset_cmd),
  .door_latch_release_a(door_latch_release_a), .teach_mode_sel(teach_mode_sel), .safety_active_ff(safety_active_ff),
  .door_latched_ff(door_latched_ff), .teach_latched_ff(teach_latched_ff), .estop_active_ff(estop_active_ff),
  .critical_error_ff(critical_error_ff));

// ---- sim_switch_model.sv ----
// Purpose: door switch, stop button and latch release switch
// Assumes: contacts high when closed
// Notes: a fault opens channel two alone
`timescale 1ns/1ps
module sim_switch_model (
  input wire logic door_open, stop_pressed, release_closed, door_fault, stop_fault,
  output logic door_one, door_two, stop_one, stop_two, release_pin
);
  assign door_one = !door_open;
  assign door_two = !door_open && !door_fault;
  assign stop_one = !stop_pressed;
  assign stop_two = !stop_pressed && !stop_fault;
  assign release_pin = release_closed;
endmodule : sim_switch_model

// ---- sim_safety_monitor_tb_top.sv ----
// Purpose: testbench of the safety interlock monitor
// Assumes: short disagreement limit
// Notes: state vector is safe, latch, teach, stop, critical, pause, prohibit
`timescale 1ns/1ps
module sim_safety_monitor_tb_top;
  localparam int unsigned LIM = 20;
  logic clk_sys = 1'b0, rst_n = 1'b0, reset_cmd = 1'b0, teach = 1'b0, d_open = 1'b1, s_press = 1'b1, rel = 1'b0;
  logic [1:0] flt = 2'h0;
  logic d1, d2, s1, s2, rp;
  wire [6:0] st;
  int error_cnt = 0, checked = 0, cyc = 0;
  sim_switch_model sw (.door_open(d_open), .stop_pressed(s_press), .release_closed(rel), .door_fault(flt[0]),
    .stop_fault(flt[1]), .door_one(d1), .door_two(d2), .stop_one(s1), .stop_two(s2), .release_pin(rp));
  sim_safety_monitor #(.DISAGREE_LIMIT(LIM)) uut (.clk_sys(clk_sys), .rst_n(rst_n), .door_channel_one_a(d1),
    .door_channel_two_a(d2), .stop_contact_one_a(s1), .stop_contact_two_a(s2), .door_latch_release_a(rp),
    .teach_mode_sel(teach), .reset_cmd(reset_cmd), .safety_active_ff(st[6]), .door_latched_ff(st[5]),
    .teach_latched_ff(st[4]), .estop_active_ff(st[3]), .critical_error_ff(st[2]), .program_pause_ff(st[1]),
    .motion_prohibit_ff(st[0]));
  initial forever #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic wt(input int n); repeat (n) @(negedge clk_sys); endtask : wt
  task automatic chk(input string n, input logic [6:0] s, input logic [6:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", n, e, s);
    end
  endtask : chk
  task automatic pulse_reset; reset_cmd = 1'b1; wt(1); reset_cmd = 1'b0; wt(2); endtask : pulse_reset
  task automatic t_start;
    rst_n = 1'b1; wt(10); chk("start open door pressed stop", st, 7'h6B);
  endtask : t_start
  task automatic t_stop;
    s_press = 1'b0; wt(10); chk("stop held", st, 7'h6B);
    pulse_reset(); chk("stop cleared", st, 7'h63);
  endtask : t_stop
  task automatic t_door;
    rel = 1'b1; wt(10); chk("release on open door", st, 7'h63);
    d_open = 1'b0; wt(10); chk("latch after close", st, 7'h61);
    rel = 1'b0; wt(10); rel = 1'b1; wt(10); chk("latch cleared", st, 7'h00);
    d_open = 1'b1; wt(10); chk("follow open", st, 7'h43);
    d_open = 1'b0; wt(10); chk("follow close", st, 7'h00);
  endtask : t_door
  task automatic t_teach;
    rel = 1'b0; wt(10); teach = 1'b1; wt(10); chk("teach latched", st, 7'h11);
    rel = 1'b1; wt(10); chk("teach still latched", st, 7'h11);
    rel = 1'b0; d_open = 1'b1; wt(10); teach = 1'b0; wt(10); rel = 1'b1; wt(10);
    chk("teach cleared door open", st, 7'h63);
    d_open = 1'b0; wt(10); rel = 1'b0; wt(10); rel = 1'b1; wt(10); chk("all clear", st, 7'h00);
  endtask : t_teach
  task automatic t_pair(input int i);
    logic [6:0] b;
    b = (i == 1) ? 7'h09 : 7'h00;
    flt[i] = 1'b1; wt(LIM - 5); flt[i] = 1'b0; wt(10); chk("short disagreement", st, b);
    flt[i] = 1'b1; wt(LIM + 10); flt[i] = 1'b0; wt(10); chk("critical", st, b | 7'h05);
    pulse_reset(); chk("critical cleared", st, 7'h00);
  endtask : t_pair
  task automatic complete_run;
    if (error_cnt == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  initial begin
    wt(2);
    t_start();
    t_stop();
    t_door();
    t_teach();
    t_pair(0);
    t_pair(1);
    complete_run();
  end
endmodule : sim_safety_monitor_tb_top
